// File: logic/hbd_engine.v
/*
  Host buffer descriptor engine: APB register file, descriptor list
  walker and attributes structure writer over a 16-byte host memory port.
  Assumes a host memory port that holds read data with its acknowledge
  and an APB master that keeps each request steady until pready.
*/
`timescale 1ns/1ps
`include "hbd_consts.vh"

module hbd_engine (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         psel_in,
  input  wire         penable_in,
  input  wire         pwrite_in,
  input  wire [7:0]   paddr_in,
  input  wire [31:0]  pwdata_in,
  output reg          pready_out,
  output reg  [31:0]  prdata_out,
  output reg          pslverr_out,
  output reg          mem_req_out,
  output reg          mem_we_out,
  output reg  [63:0]  mem_addr_out,
  output reg  [127:0] mem_wdata_out,
  input  wire         mem_ack_in,
  input  wire [127:0] mem_rdata_in
);

  localparam [2:0] S_IDLE  = 3'h1;
  localparam [2:0] S_FETCH = 3'h2;
  localparam [2:0] S_QUERY = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function [3:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `HBD_OFS_CTRL:       reg_sel = `HBD_R_CTRL;
        `HBD_OFS_PAGE_TOTAL: reg_sel = `HBD_R_PAGE_TOTAL;
        `HBD_OFS_LIST_LO:    reg_sel = `HBD_R_LIST_LO;
        `HBD_OFS_LIST_HI:    reg_sel = `HBD_R_LIST_HI;
        `HBD_OFS_ENTRY_CNT:  reg_sel = `HBD_R_ENTRY_CNT;
        `HBD_OFS_DBUF_LO:    reg_sel = `HBD_R_DBUF_LO;
        `HBD_OFS_DBUF_HI:    reg_sel = `HBD_R_DBUF_HI;
        `HBD_OFS_STATUS:     reg_sel = `HBD_R_STATUS;
        `HBD_OFS_CPL_DW0:    reg_sel = `HBD_R_CPL_DW0;
        `HBD_OFS_DESC_SEL:   reg_sel = `HBD_R_DESC_SEL;
        `HBD_OFS_DESC_LO:    reg_sel = `HBD_R_DESC_LO;
        `HBD_OFS_DESC_HI:    reg_sel = `HBD_R_DESC_HI;
        `HBD_OFS_DESC_PAGES: reg_sel = `HBD_R_DESC_PAGES;
        default:             reg_sel = `HBD_R_NONE;
      endcase
    end
  endfunction

  reg                  enable_q;
  reg  [31:0]          page_total_q;
  reg  [63:0]          list_base_q;
  reg  [31:0]          entry_cnt_q;
  reg  [63:0]          dbuf_q;
  reg                  fetch_done_q;
  reg                  query_done_q;
  reg                  overflow_q;
  reg  [3:0]           valid_cnt_q;
  reg  [`HBD_IDX_W-1:0] desc_sel_q;
  reg  [2:0]           state_q;
  reg  [31:0]          idx_q;
  reg  [8:0]           beat_q;
  reg                  fetch_go;
  reg                  query_go;
  reg                  st_wr;
  reg                  st_fetch_set;
  reg                  st_query_set;
  wire [63:0]          rd_base;
  wire [31:0]          rd_pages;
  wire [3:0]           sel;
  wire                 take;
  wire                 store_en;
  wire                 last_idx;
  wire [63:0]          list_aligned;

  assign sel  = reg_sel(paddr_in);
  // Write takes effect at the edge where pready is seen high
  assign take = psel_in & penable_in & pready_out;
  // Bits 3:0 of the list address are forced to zero
  assign list_aligned = list_base_q & `HBD_LIST_ALIGN_MASK;
  assign store_en = (state_q == S_FETCH) & mem_req_out & mem_ack_in &
                    (idx_q < {28'h0, `HBD_DEPTH});
  assign last_idx = (idx_q + 32'h1) >= entry_cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Descriptor store
  hbd_desc_store u_store (
    .clk_in      (clk_in),
    .wr_en_in    (store_en),
    .wr_idx_in   (idx_q[`HBD_IDX_W-1:0]),
    .wr_base_in  (mem_rdata_in[`HBD_DESC_ADDR_MSB:`HBD_DESC_ADDR_LSB]),
    .wr_pages_in (mem_rdata_in[`HBD_DESC_PAGES_MSB:
                               `HBD_DESC_PAGES_LSB]),
    .rd_idx_in   (desc_sel_q),
    .rd_base_out (rd_base),
    .rd_pages_out(rd_pages)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decoded write strobes and done flag set strobes
  always @* begin
    fetch_go = take & pwrite_in & (sel == `HBD_R_CTRL) &
               pwdata_in[`HBD_CTRL_FETCH] & pwdata_in[`HBD_CTRL_ENABLE];
    query_go = take & pwrite_in & (sel == `HBD_R_CTRL) &
               pwdata_in[`HBD_CTRL_QUERY];
    st_wr    = take & pwrite_in & (sel == `HBD_R_STATUS);
    st_fetch_set = (state_q == S_FETCH) &
                   ((mem_req_out & mem_ack_in & last_idx) |
                    (~mem_req_out & (entry_cnt_q == 32'h0)));
    st_query_set = (state_q == S_QUERY) & mem_req_out & mem_ack_in &
                   (beat_q == `HBD_ATTR_BEATS - 9'h1);
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: pready one cycle into the access phase
  always @(posedge clk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out &
                     (sel == `HBD_R_NONE);
      if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
        case (sel)
          `HBD_R_CTRL:       prdata_out <= {31'h0, enable_q};
          `HBD_R_PAGE_TOTAL: prdata_out <= page_total_q;
          `HBD_R_LIST_LO:    prdata_out <= list_aligned[31:0];
          `HBD_R_LIST_HI:    prdata_out <= list_aligned[63:32];
          `HBD_R_ENTRY_CNT:  prdata_out <= entry_cnt_q;
          `HBD_R_DBUF_LO:    prdata_out <= dbuf_q[31:0];
          `HBD_R_DBUF_HI:    prdata_out <= dbuf_q[63:32];
          `HBD_R_STATUS:     prdata_out <= {20'h0, valid_cnt_q, 4'h0,
                                            overflow_q, query_done_q,
                                            fetch_done_q,
                                            (state_q != S_IDLE)};
          `HBD_R_CPL_DW0:    prdata_out <= {31'h0, enable_q};
          `HBD_R_DESC_SEL:   prdata_out <= {29'h0, desc_sel_q};
          `HBD_R_DESC_LO:    prdata_out <= rd_base[31:0];
          `HBD_R_DESC_HI:    prdata_out <= rd_base[63:32];
          `HBD_R_DESC_PAGES: prdata_out <= rd_pages;
          default:           prdata_out <= 32'h0;
        endcase
      end else begin
        prdata_out <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers; page total, list base and entry count are frozen while enabled
  always @(posedge clk_in) begin
    if (rst_in) begin
      enable_q     <= 1'b0;
      page_total_q <= 32'h0;
      list_base_q  <= 64'h0;
      entry_cnt_q  <= 32'h0;
      dbuf_q       <= 64'h0;
      desc_sel_q   <= {`HBD_IDX_W{1'b0}};
    end else if (take & pwrite_in) begin
      case (sel)
        `HBD_R_CTRL:       enable_q <= pwdata_in[`HBD_CTRL_ENABLE];
        `HBD_R_PAGE_TOTAL: if (!enable_q) page_total_q <= pwdata_in;
        `HBD_R_LIST_LO:    if (!enable_q) list_base_q[31:0] <= pwdata_in;
        `HBD_R_LIST_HI:    if (!enable_q) list_base_q[63:32] <= pwdata_in;
        `HBD_R_ENTRY_CNT:  if (!enable_q) entry_cnt_q <= pwdata_in;
        `HBD_R_DBUF_LO:    dbuf_q[31:0] <= pwdata_in;
        `HBD_R_DBUF_HI:    dbuf_q[63:32] <= pwdata_in;
        `HBD_R_DESC_SEL:   desc_sel_q <= pwdata_in[`HBD_IDX_W-1:0];
        default:           enable_q <= enable_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky done flags: write one clears, a new set wins
  always @(posedge clk_in) begin
    if (rst_in) begin
      fetch_done_q <= 1'b0;
      query_done_q <= 1'b0;
    end else begin
      if (st_fetch_set)
        fetch_done_q <= 1'b1;
      else if (st_wr & pwdata_in[`HBD_ST_FETCH_DONE])
        fetch_done_q <= 1'b0;
      if (st_query_set)
        query_done_q <= 1'b1;
      else if (st_wr & pwdata_in[`HBD_ST_QUERY_DONE])
        query_done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // List walker and attributes writer
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q       <= S_IDLE;
      idx_q         <= 32'h0;
      beat_q        <= 9'h0;
      valid_cnt_q   <= 4'h0;
      overflow_q    <= 1'b0;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 64'h0;
      mem_wdata_out <= 128'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          idx_q  <= 32'h0;
          beat_q <= 9'h0;
          if (fetch_go & ~enable_q) begin
            state_q     <= S_FETCH;
            valid_cnt_q <= 4'h0;
            overflow_q  <= 1'b0;
          end else if (query_go) begin
            state_q       <= S_QUERY;
            mem_req_out   <= 1'b1;
            mem_we_out    <= 1'b1;
            mem_addr_out  <= dbuf_q;
            // First beat carries the fields, the rest is zero
            mem_wdata_out <= {entry_cnt_q, list_aligned[63:32],
                              list_aligned[31:0], page_total_q};
          end
        end
        S_FETCH: begin
          if (~enable_q) begin
            mem_req_out <= 1'b0;
            state_q     <= S_IDLE;
          end else if (~mem_req_out) begin
            if (entry_cnt_q == 32'h0) begin
              state_q <= S_IDLE;
            end else begin
              mem_req_out  <= 1'b1;
              mem_we_out   <= 1'b0;
              // Record k sits 16 bytes times k past the list base
              mem_addr_out <= list_aligned +
                              {28'h0, idx_q, `HBD_REC_SHIFT};
            end
          end else if (mem_ack_in) begin
            if (store_en)
              valid_cnt_q <= valid_cnt_q + 4'h1;
            else
              overflow_q <= 1'b1;
            if (last_idx) begin
              mem_req_out <= 1'b0;
              state_q     <= S_IDLE;
            end else begin
              idx_q        <= idx_q + 32'h1;
              mem_addr_out <= mem_addr_out + `HBD_REC_BYTES;
            end
          end
        end
        S_QUERY: begin
          if (mem_ack_in) begin
            mem_wdata_out <= 128'h0;
            if (beat_q == `HBD_ATTR_BEATS - 9'h1) begin
              mem_req_out <= 1'b0;
              mem_we_out  <= 1'b0;
              state_q     <= S_IDLE;
            end else begin
              beat_q       <= beat_q + 9'h1;
              mem_addr_out <= mem_addr_out + `HBD_REC_BYTES;
            end
          end
        end
        default: begin
          state_q     <= S_IDLE;
          mem_req_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: logic/hbd_consts.vh
/*
  Constants for the host buffer descriptor engine: register byte offsets,
  control and status bit positions, descriptor field positions and the
  sizes of the descriptor record and of the attributes structure.
  Assumes inclusion by bare name from the design files.
*/
`ifndef HBD_CONSTS_VH
`define HBD_CONSTS_VH

// Register byte offsets (one aligned 32-bit word each)
`define HBD_OFS_CTRL        8'h00
`define HBD_OFS_PAGE_TOTAL  8'h04
`define HBD_OFS_LIST_LO     8'h08
`define HBD_OFS_LIST_HI     8'h0c
`define HBD_OFS_ENTRY_CNT   8'h10
`define HBD_OFS_DBUF_LO     8'h14
`define HBD_OFS_DBUF_HI     8'h18
`define HBD_OFS_STATUS      8'h1c
`define HBD_OFS_CPL_DW0     8'h20
`define HBD_OFS_DESC_SEL    8'h24
`define HBD_OFS_DESC_LO     8'h28
`define HBD_OFS_DESC_HI     8'h2c
`define HBD_OFS_DESC_PAGES  8'h30

// Register decode indices
`define HBD_R_NONE          4'h0
`define HBD_R_CTRL          4'h1
`define HBD_R_PAGE_TOTAL    4'h2
`define HBD_R_LIST_LO       4'h3
`define HBD_R_LIST_HI       4'h4
`define HBD_R_ENTRY_CNT     4'h5
`define HBD_R_DBUF_LO       4'h6
`define HBD_R_DBUF_HI       4'h7
`define HBD_R_STATUS        4'h8
`define HBD_R_CPL_DW0       4'h9
`define HBD_R_DESC_SEL      4'ha
`define HBD_R_DESC_LO       4'hb
`define HBD_R_DESC_HI       4'hc
`define HBD_R_DESC_PAGES    4'hd

// Control bits
`define HBD_CTRL_ENABLE     0
`define HBD_CTRL_FETCH      1
`define HBD_CTRL_QUERY      2

// Status bits
`define HBD_ST_BUSY         0
`define HBD_ST_FETCH_DONE   1
`define HBD_ST_QUERY_DONE   2
`define HBD_ST_OVERFLOW     3

// Descriptor record fields
`define HBD_DESC_ADDR_MSB   63
`define HBD_DESC_ADDR_LSB   0
`define HBD_DESC_PAGES_MSB  95
`define HBD_DESC_PAGES_LSB  64

// Record and structure sizes
`define HBD_REC_SHIFT       4'h0
`define HBD_REC_BYTES       64'h10
`define HBD_LIST_ALIGN_MASK 64'hffff_ffff_ffff_fff0
`define HBD_ATTR_BEATS      9'h100
`define HBD_DEPTH           4'h8
`define HBD_IDX_W           3

`endif

// File: logic/hbd_desc_store.v
/*
  Descriptor store: holds the chunk base address and chunk page count
  of the first 8 fetched descriptors, one write port and one registered read port.
  Assumes one clock and a caller that keeps the index in range.
*/
`timescale 1ns/1ps
`include "hbd_consts.vh"

module hbd_desc_store (
  input  wire                  clk_in,
  input  wire                  wr_en_in,
  input  wire [`HBD_IDX_W-1:0] wr_idx_in,
  input  wire [63:0]           wr_base_in,
  input  wire [31:0]           wr_pages_in,
  input  wire [`HBD_IDX_W-1:0] rd_idx_in,
  output reg  [63:0]           rd_base_out,
  output reg  [31:0]           rd_pages_out
);

  reg [63:0] base_mem [0:`HBD_DEPTH-1];
  reg [31:0] page_mem [0:`HBD_DEPTH-1];

  // Write one record, read one record a cycle later
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      base_mem[wr_idx_in] <= wr_base_in;
      page_mem[wr_idx_in] <= wr_pages_in;
    end
    rd_base_out  <= base_mem[rd_idx_in];
    rd_pages_out <= page_mem[rd_idx_in];
  end

endmodule

// File: tb/hbd_engine_assertions.sv
/*
  Checker for the descriptor engine: APB answer timing and host memory
  beat order. Assumes it is bound onto hbd_engine and sees its ports only.
*/
`timescale 1ns/1ps
module hbd_engine_assertions (
  input wire         clk_in,
  input wire         rst_in,
  input wire         psel_in,
  input wire         penable_in,
  input wire         pwrite_in,
  input wire [7:0]   paddr_in,
  input wire [31:0]  pwdata_in,
  input wire         pready_out,
  input wire [31:0]  prdata_out,
  input wire         pslverr_out,
  input wire         mem_req_out,
  input wire         mem_we_out,
  input wire [63:0]  mem_addr_out,
  input wire [127:0] mem_wdata_out,
  input wire         mem_ack_in,
  input wire [127:0] mem_rdata_in
);
  reg en_q;
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the use enable, taken from completed control writes
  always @(posedge clk_in) begin
    if (rst_in) begin
      en_q <= 1'b0;
    end else if (psel_in && penable_in && pready_out && pwrite_in &&
                 paddr_in == 8'h00) begin
      en_q <= pwdata_in[0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready_out |->
    psel_in && penable_in && $past(psel_in && penable_in))
    else $error("pready without two access cycles");
  a_err_unmapped: assert property (pready_out && paddr_in > 8'h30 |->
    pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_req_hold: assert property (
    mem_req_out && !mem_ack_in && (en_q || mem_we_out) |=>
    mem_req_out && $stable(mem_addr_out)
    && $stable(mem_we_out) && $stable(mem_wdata_out))
    else $error("memory request changed before accept");
  a_read_step: assert property (
    mem_req_out && mem_ack_in && !mem_we_out ##1 mem_req_out && !mem_we_out
    |-> mem_addr_out == $past(mem_addr_out) + 64'h10)
    else $error("record address not 16 bytes on");
  a_list_align: assert property (
    mem_req_out && !mem_we_out |-> mem_addr_out[3:0] == 4'h0)
    else $error("record read not 16-byte aligned");
  a_attr_zero: assert property (
    mem_req_out && mem_we_out && mem_ack_in |=>
    !mem_req_out || mem_wdata_out == 128'h0)
    else $error("reserved attribute bytes not zero");
  a_no_access: assert property (
    mem_req_out && !mem_we_out |-> en_q || $past(en_q))
    else $error("host buffer read while disabled");
endmodule

bind hbd_engine hbd_engine_assertions i_hbd_engine_assertions (
  .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .mem_req_out,
  .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in);

// File: tb/hbd_host_mem.sv
/*
  Host memory model: answers 16-byte beats after 0 to 3 wait cycles and
  logs reads and attribute writes. Assumes requests held until accept.
*/
`timescale 1ns/1ps
module hbd_host_mem (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         mem_req_in,
  input  wire         mem_we_in,
  input  wire [63:0]  mem_addr_in,
  input  wire [127:0] mem_wdata_in,
  output reg          mem_ack_out,
  output reg  [127:0] mem_rdata_out
);
  reg [1:0]   wait_q = 2'h0;
  int         rd_cnt = 0;
  int         wr_cnt = 0;
  int         zero_bad = 0;
  reg [63:0]  rd_last = 64'h0;
  reg [63:0]  wr_first_addr = 64'h0;
  reg [127:0] wr_first = 128'h0;
  initial mem_ack_out = 1'b0;
  initial mem_rdata_out = 128'h0;
  // Fixed list contents, base 64KB aligned, reserved word nonzero
  function automatic [127:0] desc_of(input [63:0] a);
    desc_of = {32'ha5a5_5a5a, 16'h0, a[19:4], a[51:4], 16'h0};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Beat log and accept; data flips every cycle while not answering
  always @(posedge clk_in) begin
    if (mem_req_in && mem_ack_out) begin
      if (!mem_we_in) begin
        rd_cnt <= rd_cnt + 1;
        rd_last <= mem_addr_in;
      end else if (wr_cnt % 256 == 0) begin
        wr_first <= mem_wdata_in;
        wr_first_addr <= mem_addr_in;
      end else if (mem_wdata_in !== 128'h0) begin
        zero_bad <= zero_bad + 1;
      end
      if (mem_we_in) wr_cnt <= wr_cnt + 1;
    end
    if (rst_in || !mem_req_in || mem_ack_out || wait_q != 2'h0) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      wait_q <= (wait_q != 2'h0) ? wait_q - 2'h1 : 2'($urandom % 4);
    end else begin
      mem_ack_out <= 1'b1;
      mem_rdata_out <= desc_of(mem_addr_in);
    end
  end
endmodule

// File: tb/host_buffer_descriptor_list_tb_top.sv
/*
  Testbench: fills parameters over APB, enables with fetch, reads stored
  descriptors, queries attributes, disables. Assumes hbd_host_mem model.
*/
`timescale 1ns/1ps
module host_buffer_descriptor_list_tb_top;
  reg          clk_in = 1'b0;
  reg          rst_in = 1'b1;
  reg          psel_in = 1'b0;
  reg          penable_in = 1'b0;
  reg          pwrite_in = 1'b0;
  reg  [7:0]   paddr_in = 8'h00;
  reg  [31:0]  pwdata_in = 32'h0;
  wire         pready_out, pslverr_out, mem_req_out, mem_we_out, mem_ack_in;
  wire [31:0]  prdata_out;
  wire [63:0]  mem_addr_out;
  wire [127:0] mem_wdata_out, mem_rdata_in;
  reg  [31:0]  rdat;
  reg          rerr;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #12.5 clk_in = ~clk_in;
  hbd_engine i_hbd_engine (.clk_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out,
    .pslverr_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
    .mem_ack_in, .mem_rdata_in);
  hbd_host_mem i_hbd_host_mem (.clk_in, .rst_in, .mem_req_in(mem_req_out),
    .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out),
    .mem_wdata_in(mem_wdata_out), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input [127:0] got, input [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input bit w, input [7:0] a, input [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do @(posedge clk_in); while (pready_out !== 1'b1 && ++n < 20);
    if (n >= 20) bad_count++;
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do apb(0, 8'h1c, 0); while (rdat[b] !== 1'b1 && ++n < 400);
    chk(rdat[b], 1'b1);
  endtask
  // Timeout guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int t, k, cnt, r0, w0;
    reg [31:0]  lo, hi, pt, db;
    reg [63:0]  la;
    reg [127:0] d;
    k = $urandom(12);
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(0, 8'h1c, 0);
    chk(rdat, 0);
    apb(0, 8'h44, 0);
    chk({rerr, rdat}, 33'h1_0000_0000);
    for (t = 0; t < 3; t++) begin
      cnt = (t == 0) ? 0 : (t == 1) ? 1 + $urandom % 7 : 9;
      lo = $urandom;
      hi = $urandom;
      pt = $urandom;
      la = {hi, lo & ~32'hf};
      apb(1, 8'h04, pt);
      apb(1, 8'h08, lo);
      apb(1, 8'h0c, hi);
      apb(1, 8'h10, cnt);
      apb(0, 8'h08, 0);
      chk(rdat, lo & ~32'hf);
      if (t == 2) begin
        // Enable with fetch, then disable at once: the walk must stop
        r0 = i_hbd_host_mem.rd_cnt;
        apb(1, 8'h00, 3);
        apb(1, 8'h00, 0);
        apb(0, 8'h1c, 0);
        chk(rdat[2:0], 0);
        chk(i_hbd_host_mem.rd_cnt - r0 < cnt, 1);
        r0 = i_hbd_host_mem.rd_cnt;
        repeat (20) @(posedge clk_in);
        chk(i_hbd_host_mem.rd_cnt - r0, 0);
      end
      r0 = i_hbd_host_mem.rd_cnt;
      apb(1, 8'h00, 3);
      wait_st(1);
      chk(i_hbd_host_mem.rd_cnt - r0, cnt);
      if (cnt > 0)
        chk(i_hbd_host_mem.rd_last, la + 16 * (cnt - 1));
      apb(0, 8'h1c, 0);
      chk(rdat[11:8], cnt > 8 ? 8 : cnt);
      chk(rdat[3], cnt > 8);
      for (k = 0; k < cnt && k < 8; k++) begin
        d = i_hbd_host_mem.desc_of(la + 16 * k);
        apb(1, 8'h24, k);
        @(posedge clk_in);
        apb(0, 8'h28, 0);
        chk(rdat, d[31:0]);
        apb(0, 8'h2c, 0);
        chk(rdat, d[63:32]);
        apb(0, 8'h30, 0);
        chk(rdat, d[95:64]);
      end
      db = 32'h8000_0000 + t * 32'h1_0000;
      apb(1, 8'h14, db);
      apb(1, 8'h18, hi);
      w0 = i_hbd_host_mem.wr_cnt;
      apb(1, 8'h00, 5);
      wait_st(2);
      chk(i_hbd_host_mem.wr_cnt - w0, 256);
      chk(i_hbd_host_mem.wr_first, {cnt, la, pt});
      chk(i_hbd_host_mem.wr_first_addr, {hi, db});
      chk(i_hbd_host_mem.zero_bad, 0);
      apb(0, 8'h20, 0);
      chk(rdat, 1);
      apb(1, 8'h1c, 6);
      apb(1, 8'h00, 0);
      apb(0, 8'h20, 0);
      chk(rdat, 0);
    end
    final_report();
  end
endmodule
